// >>> core/rgc_gate_ctrl.sv
// roll gate controller top: contactors and warning flasher
`include "rgc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module rgc_gate_ctrl
    import rgc_pkg::*;
#(
    parameter int WARN_CYC = `RGC_WARN_CYC,
    parameter int FLASH_CYC = `RGC_FLASH_CYC,
    parameter int CNT_W = `RGC_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic stop_button_i,
    input wire logic open_button_i,
    input wire logic close_button_i,
    input wire logic opened_limit_switch_i,
    input wire logic closed_limit_switch_i,
    input wire logic safety_bar_i,
    output logic open_contactor_o,
    output logic close_contactor_o,
    output logic flasher_o,
    output logic moving_o
);
    // ************************************************************
    // input conditioning
    // ************************************************************
    rgc_in_if in_if ();

    // all six gate inputs are active high at this port (rst_n_i is active low); pins are asynchronous
    rgc_in_sync #(
        .W(6)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .raw_i({safety_bar_i, closed_limit_switch_i,
                opened_limit_switch_i, close_button_i,
                open_button_i, stop_button_i}),
        .sync(in_if.src)
    );

    // ************************************************************
    // helpers
    // ************************************************************

    // last cycle of a count that runs len cycles from zero
    function automatic logic count_done(
        input logic [CNT_W-1:0] q,
        input int len
    );
        return q == CNT_W'(len - 1);
    endfunction : count_done

    // counter step; wraps only past the widest count, never reached
    function automatic logic [CNT_W-1:0] count_up(
        input logic [CNT_W-1:0] q
    );
        return q + CNT_W'(1);
    endfunction : count_up

    // end position reached for the direction being announced or run
    function automatic logic limit_hit(
        input rgc_state_e st,
        input logic opened,
        input logic closed
    );
        return ((st == RGC_WARN_OPEN || st == RGC_OPENING) && opened) ||
               ((st == RGC_WARN_CLOSE || st == RGC_CLOSING) && closed);
    endfunction : limit_hit

    // ************************************************************
    // travel state machine
    // ************************************************************
    rgc_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] fcnt_q, fcnt_d;
    logic blink_q, blink_d;
    logic open_q, open_d;
    logic close_q, close_d;
    logic flash_q, flash_d;
    logic moving_q, moving_d;
    logic stop_req;

    // stop halts anywhere, including during the pre-warning
    assign stop_req = in_if.stop_button;

    // next state and pre-warning counter
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            RGC_IDLE: begin
                cnt_d = '0;
                // open wins if both pressed; closing needs bar clear
                if (stop_req) begin
                    state_d = RGC_IDLE;
                end else if (in_if.open_button &&
                             !in_if.opened_limit_switch) begin
                    state_d = RGC_WARN_OPEN;
                end else if (in_if.close_button &&
                             !in_if.closed_limit_switch &&
                             !in_if.safety_bar) begin
                    state_d = RGC_WARN_CLOSE;
                end
            end
            RGC_WARN_OPEN, RGC_WARN_CLOSE: begin
                // motor held off while the warning runs
                if (stop_req) begin
                    state_d = RGC_IDLE;
                end else if (state_q == RGC_WARN_CLOSE &&
                             in_if.safety_bar) begin
                    state_d = RGC_IDLE;
                end else if (limit_hit(state_q,
                                       in_if.opened_limit_switch,
                                       in_if.closed_limit_switch)) begin
                    // end position already there: nothing to announce
                    state_d = RGC_IDLE;
                end else if (count_done(cnt_q, WARN_CYC)) begin
                    state_d = (state_q == RGC_WARN_OPEN) ?
                              RGC_OPENING : RGC_CLOSING;
                end else begin
                    cnt_d = count_up(cnt_q);
                end
            end
            RGC_OPENING: begin
                // close presses are ignored until halted
                if (stop_req || limit_hit(state_q,
                                          in_if.opened_limit_switch,
                                          in_if.closed_limit_switch)) begin
                    state_d = RGC_IDLE;
                end
            end
            RGC_CLOSING: begin
                // open presses are ignored until halted
                if (stop_req || in_if.safety_bar ||
                    limit_hit(state_q, in_if.opened_limit_switch,
                              in_if.closed_limit_switch)) begin
                    state_d = RGC_IDLE;
                end
            end
            default: begin
                // three unused codes: fall back to a halted gate
                state_d = RGC_IDLE;
            end
        endcase
    end

    // ************************************************************
    // outputs and flasher
    // ************************************************************

    // outputs registered from the next state so safety bar acts at once
    always_comb begin
        // break before make: each contactor waits for the other to drop
        open_d = (state_d == RGC_OPENING) && !close_q;
        close_d = (state_d == RGC_CLOSING) && !open_q;
        moving_d = (state_d != RGC_IDLE);
        fcnt_d = fcnt_q;
        blink_d = blink_q;
        if (state_d == RGC_IDLE) begin
            // flasher stops with the gate
            fcnt_d = '0;
            blink_d = 1'b0;
        end else if (state_q == RGC_IDLE) begin
            fcnt_d = '0;
            blink_d = 1'b1;
        end else if (count_done(fcnt_q, FLASH_CYC)) begin
            fcnt_d = '0;
            blink_d = !blink_q;
        end else begin
            fcnt_d = count_up(fcnt_q);
        end
        flash_d = blink_d;
    end

    // travel state registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= RGC_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // output and flasher registers; every port leaves a flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fcnt_q <= '0;
            blink_q <= 1'b0;
            open_q <= 1'b0;
            close_q <= 1'b0;
            flash_q <= 1'b0;
            moving_q <= 1'b0;
        end else begin
            fcnt_q <= fcnt_d;
            blink_q <= blink_d;
            open_q <= open_d;
            close_q <= close_d;
            flash_q <= flash_d;
            moving_q <= moving_d;
        end
    end

    // ************************************************************
    // ports
    // ************************************************************
    // contactors, lamp and status straight from their flops
    assign open_contactor_o = open_q;
    assign close_contactor_o = close_q;
    assign flasher_o = flash_q;
    assign moving_o = moving_q;

endmodule : rgc_gate_ctrl

`default_nettype wire

// >>> core/rgc_consts.svh
// timing constants for the roll gate controller
`ifndef RGC_CONSTS_SVH
`define RGC_CONSTS_SVH

// clock rate in hertz
`define RGC_CLK_HZ 40000000
// pre-warning time in seconds
`define RGC_WARN_S 5
// pre-warning count in clock cycles
`define RGC_WARN_CYC (`RGC_WARN_S * `RGC_CLK_HZ)
// flasher half period in milliseconds
`define RGC_FLASH_MS 500
`define RGC_FLASH_CYC (`RGC_FLASH_MS * (`RGC_CLK_HZ / 1000))
// counter width, enough for the pre-warning count
`define RGC_CNT_W 28

`endif

// >>> core/rgc_pkg.sv
// types of the roll gate controller
package rgc_pkg;

    // gate travel states
    typedef enum logic [2:0] {
        RGC_IDLE,
        RGC_WARN_OPEN,
        RGC_WARN_CLOSE,
        RGC_OPENING,
        RGC_CLOSING
    } rgc_state_e;

endpackage : rgc_pkg

// >>> core/rgc_in_if.sv
// interface carrying the filtered gate inputs
`timescale 1ns/10ps
`default_nettype none

interface rgc_in_if;
    logic stop_button;
    logic open_button;
    logic close_button;
    logic opened_limit_switch;
    logic closed_limit_switch;
    logic safety_bar;

    modport src (
        output stop_button, open_button, close_button,
        output opened_limit_switch, closed_limit_switch, safety_bar
    );
    modport dst (
        input stop_button, open_button, close_button,
        input opened_limit_switch, closed_limit_switch, safety_bar
    );
endinterface : rgc_in_if

`default_nettype wire

// >>> core/rgc_in_sync.sv
// three-stage input synchroniser with agreement check
`timescale 1ns/10ps
`default_nettype none

module rgc_in_sync #(
    parameter int W = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] raw_i,
    rgc_in_if.src sync
);
    logic [W-1:0] s1_q, s2_q, s3_q, val_q;
    logic [W-1:0] s1_d, s2_d, s3_d, val_d;

    // next values: a change counts once stages two and three agree
    always_comb begin
        s1_d = raw_i;
        s2_d = s1_q;
        s3_d = s2_q;
        val_d = val_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                val_d[i] = s3_q[i];
            end
        end
    end

    // registers; stage one feeds stage two only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            val_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            val_q <= val_d;
        end
    end

    assign sync.stop_button = val_q[0];
    assign sync.open_button = val_q[1];
    assign sync.close_button = val_q[2];
    assign sync.opened_limit_switch = val_q[3];
    assign sync.closed_limit_switch = val_q[4];
    assign sync.safety_bar = val_q[5];

endmodule : rgc_in_sync

`default_nettype wire

// >>> bench/rgc_gate_properties.sv
// port checks for the roll gate controller
`timescale 1ns/10ps
`default_nettype none
module rgc_gate_properties #(
    parameter int WARN_CYC = 20,
    parameter int FLASH_CYC = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic stop_button_i,
    input wire logic open_button_i,
    input wire logic close_button_i,
    input wire logic opened_limit_switch_i,
    input wire logic closed_limit_switch_i,
    input wire logic safety_bar_i,
    input wire logic open_contactor_o,
    input wire logic close_contactor_o,
    input wire logic flasher_o,
    input wire logic moving_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // a level clears the input synchroniser after 4 samples and reaches the outputs by the 6th
    sequence open_held;
        (open_button_i && !stop_button_i && !opened_limit_switch_i)[*7];
    endsequence
    chk_open_start: assert property (!moving_o ##0 open_held |-> moving_o)
        else $error("open press not taken");
    // close level with nothing to refuse it; open may win instead
    sequence close_held;
        (close_button_i && !stop_button_i && !closed_limit_switch_i &&
         !safety_bar_i)[*7];
    endsequence
    chk_close_start:
        assert property (!moving_o ##0 close_held |-> moving_o)
        else $error("close press not taken");
    chk_stop_halt: assert property (stop_button_i[*7] |-> !moving_o)
        else $error("stop did not halt");
    chk_open_limit:
        assert property (opened_limit_switch_i[*7] |-> !open_contactor_o)
        else $error("open past limit");
    chk_close_limit:
        assert property (closed_limit_switch_i[*7] |-> !close_contactor_o)
        else $error("close past limit");
    chk_bar_drop: assert property (safety_bar_i[*7] |-> !close_contactor_o)
        else $error("bar ignored");
    chk_warn_len:
        assert property ($rose(open_contactor_o) || $rose(close_contactor_o)
            |-> $past(moving_o, WARN_CYC) && !$past(moving_o, WARN_CYC + 1))
        else $error("warning time wrong");
    chk_flash_move: assert property (flasher_o |-> moving_o)
        else $error("flasher while idle");
    chk_flash_start: assert property ($rose(moving_o) |-> flasher_o)
        else $error("flasher late");
    chk_one_dir:
        assert property (!(open_contactor_o && close_contactor_o))
        else $error("both contactors on");
    // cycles the flasher has held one level while the gate is busy
    logic flash_prev;
    int unsigned flash_run;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_prev <= 1'b0;
            flash_run <= '0;
        end else begin
            flash_prev <= flasher_o;
            if (!moving_o || flasher_o != flash_prev) flash_run <= '0;
            else flash_run <= flash_run + 1;
        end
    end
    chk_flash_blink: assert property (flash_run < FLASH_CYC)
        else $error("flasher stuck while moving");
endmodule : rgc_gate_properties
`default_nettype wire

// >>> bench/rgc_gate_model.sv
// gate body model: moves with the contactors, drives the limit switches
`timescale 1ns/10ps
`default_nettype none
module rgc_gate_model #(
    parameter int TRAVEL = 60
) (
    input wire logic clk_i,
    input wire logic open_contactor_i,
    input wire logic close_contactor_i,
    output logic opened_limit_switch_o,
    output logic closed_limit_switch_o
);
    int pos = TRAVEL / 2; // starts half way, not at an end
    // one step per clock; the body jams at each end stop
    always @(posedge clk_i) begin
        if (open_contactor_i && pos < TRAVEL) pos <= pos + 1;
        if (close_contactor_i && pos > 0) pos <= pos - 1;
    end
    assign opened_limit_switch_o = (pos >= TRAVEL);
    assign closed_limit_switch_o = (pos <= 0);
endmodule : rgc_gate_model
`default_nettype wire

// >>> bench/rgc_gate_ctrl_tb.sv
// self-checking bench for the roll gate controller
`timescale 1ns/10ps
`default_nettype none
module rgc_gate_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] btn = 4'h0; // bar, stop, close, open
    logic oc, cc, fl, mv, ol, cl;
    logic [2:0] notes[$];
    logic [2:0] last = 3'h0;
    logic [2:0] note;
    logic [31:0] rnd = 32'hE8AD;
    int failures = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    rgc_gate_ctrl #(.WARN_CYC(20), .FLASH_CYC(4)) rgc_gate_ctrl_i (
        .clk_i(clk), .rst_n_i(rst_n), .stop_button_i(btn[2]),
        .open_button_i(btn[0]), .close_button_i(btn[1]),
        .opened_limit_switch_i(ol), .closed_limit_switch_i(cl),
        .safety_bar_i(btn[3]), .open_contactor_o(oc),
        .close_contactor_o(cc), .flasher_o(fl), .moving_o(mv));
    rgc_gate_model rgc_gate_model_i (.clk_i(clk), .open_contactor_i(oc),
        .close_contactor_i(cc), .opened_limit_switch_o(ol),
        .closed_limit_switch_o(cl));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction : xs
    task automatic check(input string what, input logic [2:0] seen,
                         input logic [2:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", what, want, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // random hold time, short enough to end inside the warning
    task automatic press(input int b);
        int n;
        rnd = xs(rnd);
        n = 8 + rnd[1:0];
        @(negedge clk) btn[b] = 1'b1;
        repeat (n) @(negedge clk);
        btn[b] = 1'b0;
    endtask : press
    task automatic wait_for(input logic [2:0] want);
        int i;
        for (i = 0; i < 400 && {oc, cc, mv} !== want; i++) @(negedge clk);
        if (i == 400) begin
            failures++;
            report_and_stop();
        end
    endtask : wait_for
    // notes one move: warning, optional travel pattern, halt
    task automatic expect_moves(input logic [2:0] run);
        notes.push_back(3'h1);
        if (run !== 3'h0) notes.push_back(run);
        notes.push_back(3'h0);
    endtask : expect_moves
    // watcher: every change of contactors or motion takes the oldest note
    always @(negedge clk) begin
        if (rst_n && {oc, cc, mv} !== last) begin
            // an unlooked-for change meets an unknown note and fails
            note = 3'hX;
            if (notes.size() != 0) note = notes.pop_front();
            check("outputs", {oc, cc, mv}, note);
            // flasher lights with the move and goes out with the halt
            if (note[0] !== last[0]) begin
                check("flasher", {2'h0, fl}, {2'h0, note[0]});
            end
            last = {oc, cc, mv};
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        // open from mid travel to the opened limit
        expect_moves(3'h5);
        press(0);
        wait_for(3'h0);
        // close, reverse press ignored, stop part way
        expect_moves(3'h3);
        press(1);
        wait_for(3'h3);
        press(0);
        press(2);
        wait_for(3'h0);
        // close again, safety bar aborts
        expect_moves(3'h3);
        press(1);
        wait_for(3'h3);
        press(3);
        wait_for(3'h0);
        // stop inside the warning cancels the move
        expect_moves(3'h0);
        press(0);
        press(2);
        wait_for(3'h0);
        // presses refused while stop or bar is held
        btn[2] = 1'b1;
        press(0);
        press(1);
        btn[2] = 1'b0;
        btn[3] = 1'b1;
        press(1);
        btn[3] = 1'b0;
        // run down to the closed limit, then close is refused there
        expect_moves(3'h3);
        press(1);
        wait_for(3'h3);
        wait_for(3'h0);
        press(1);
        repeat (10) @(negedge clk);
        // every noted move must have shown up
        check("missing moves", {2'h0, notes.size() != 0}, 3'h0);
        report_and_stop();
    end
endmodule : rgc_gate_ctrl_tb
bind rgc_gate_ctrl rgc_gate_properties #(
    .WARN_CYC(WARN_CYC),
    .FLASH_CYC(FLASH_CYC)
) rgc_gate_properties_i (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .stop_button_i(stop_button_i),
    .open_button_i(open_button_i),
    .close_button_i(close_button_i),
    .opened_limit_switch_i(opened_limit_switch_i),
    .closed_limit_switch_i(closed_limit_switch_i),
    .safety_bar_i(safety_bar_i),
    .open_contactor_o(open_contactor_o),
    .close_contactor_o(close_contactor_o),
    .flasher_o(flasher_o),
    .moving_o(moving_o)
);
`default_nettype wire
